// ---- hw/cabx_alu.sv ----
// cabx_alu: byte and word arithmetic, logic and compare with flags
// assumes operands already selected; purely combinational
`timescale 1ns/10ps

module cabx_alu
  import cabx_pkg::*;
(
  // operation and operands
  input  cabx_op_t      op,
  input  logic [7:0]    a,
  input  logic [7:0]    ah,
  input  logic [7:0]    b,
  input  logic [7:0]    flags,
  // outcome
  output cabx_alu_res_t res
);

  // {half carry, carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] x, input logic [7:0] y, input logic ci);
    logic [4:0] nib;
    logic [8:0] sum;
    nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    sum = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    return {nib[4], sum};
  endfunction

  // {half borrow, borrow, difference}
  function automatic logic [9:0] sub8(input logic [7:0] x, input logic [7:0] y, input logic bi);
    logic [4:0] nib;
    logic [8:0] dif;
    nib = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, bi};
    dif = {1'b0, x} - {1'b0, y} - {8'h00, bi};
    return {nib[4], dif};
  endfunction

  logic [9:0]  s;
  logic [16:0] w;
  logic [7:0]  x;
  logic [7:0]  y;
  logic        chain;
  logic        upd;

  always_comb
  begin
    res       = '0;
    res.lo    = a;
    res.hi    = ah;
    res.flags = flags;
    s         = '0;
    w         = '0;
    x         = (op == OP_NEG) ? BYTE_ZERO : a;
    y         = (op == OP_NEG) ? a : b;
    chain     = op inside {OP_SUBB, OP_SUBBK, OP_CMPC};
    upd       = 1'b1;
    case (op)
      OP_ADD, OP_ADDC:
      begin
        s                 = add8(a, b, (op == OP_ADDC) && flags[FLAG_C]);
        res.lo            = s[7:0];
        res.wr            = 1'b1;
        res.flags[FLAG_C] = s[8];
        res.flags[FLAG_H] = s[9];
        res.flags[FLAG_V] = (a[7] == b[7]) && (s[7] != a[7]);
      end
      OP_SUB, OP_SUBK, OP_SUBB, OP_SUBBK, OP_CMP, OP_CMPC, OP_CMPK, OP_NEG:
      begin
        s                 = sub8(x, y, chain && flags[FLAG_C]);
        res.lo            = s[7:0];
        res.wr            = !(op inside {OP_CMP, OP_CMPC, OP_CMPK});
        res.flags[FLAG_C] = s[8];
        res.flags[FLAG_H] = s[9];
        res.flags[FLAG_V] = (x[7] != y[7]) && (s[7] != x[7]);
      end
      OP_AND, OP_ANDK, OP_OR, OP_ORK, OP_XOR, OP_SETB, OP_CLRB, OP_TEST, OP_ZERO:
      begin
        case (op)
          OP_AND, OP_ANDK: res.lo = a & b;
          OP_OR, OP_ORK:   res.lo = a | b;
          OP_XOR:          res.lo = a ^ b;
          OP_SETB:         res.lo = a | b;
          OP_CLRB:         res.lo = a & (BYTE_ONES - b);
          OP_TEST:         res.lo = a & a;
          default:         res.lo = a ^ a;
        endcase
        res.wr            = (op != OP_TEST);
        res.flags[FLAG_V] = 1'b0;
      end
      OP_COM:
      begin
        res.lo            = BYTE_ONES - a;
        res.wr            = 1'b1;
        res.flags[FLAG_C] = 1'b1;
        res.flags[FLAG_V] = 1'b0;
      end
      OP_INC, OP_DEC:
      begin
        // carry left alone so multi-byte loops can count with it
        res.lo            = (op == OP_INC) ? a + BYTE_ONE : a - BYTE_ONE;
        res.wr            = 1'b1;
        res.flags[FLAG_V] = (op == OP_INC) ? (res.lo == NEG_MIN) : (res.lo == POS_MAX);
      end
      OP_SETR:
      begin
        res.lo = BYTE_ONES;
        res.wr = 1'b1;
        upd    = 1'b0;
      end
      OP_WADD, OP_WSUB:
      begin
        w = (op == OP_WADD) ? {1'b0, ah, a} + {9'h000, b}
                            : {1'b0, ah, a} - {9'h000, b};
        {res.hi, res.lo}  = w[15:0];
        res.wr            = 1'b1;
        res.wr_pair       = 1'b1;
        res.flags[FLAG_Z] = (w[15:0] == 16'h0000);
        res.flags[FLAG_N] = w[15];
        res.flags[FLAG_V] = (op == OP_WADD) ? (!ah[7] && w[15]) : (ah[7] && !w[15]);
        res.flags[FLAG_C] = (op == OP_WADD) ? (ah[7] && !w[15]) : (!ah[7] && w[15]);
        res.flags[FLAG_S] = w[15] ^ res.flags[FLAG_V];
        upd               = 1'b0;
      end
      default:
        upd = 1'b0;
    endcase
    if (upd)
    begin
      // chained subtracts only keep zero while every byte was zero
      res.flags[FLAG_Z] = (res.lo == BYTE_ZERO) && (!chain || flags[FLAG_Z]);
      res.flags[FLAG_N] = res.lo[7];
    end
  end

endmodule

// ---- hw/cabx_core.sv ----
// cabx_core: runs one decoded instruction at a time against the working
// registers, status flags, program counter and return stack
// assumes the decoder, io_rdata and load port share clk with this core
`timescale 1ns/10ps

module cabx_core
  import cabx_pkg::*;
#(
  parameter int STACK_DEPTH = 16
)
(
  // clock and reset
  input  logic        clk,
  input  logic        rst,
  // instruction hand-off
  input  logic        instr_valid,
  input  cabx_instr_t instr,
  output logic        instr_ready,
  output logic        retire,
  // addressed I/O register contents
  input  logic [7:0]  io_rdata,
  // working register load and peek
  input  logic        load_valid,
  input  logic [4:0]  load_addr,
  input  logic [7:0]  load_data,
  input  logic [4:0]  peek_addr,
  output logic [7:0]  peek_data,
  // architectural state
  output logic [15:0] pc,
  output logic [7:0]  status_flags
);

  // ==========================================
  // decode helpers
  function automatic logic is_imm(input cabx_op_t op);
    return op inside {OP_SUBK, OP_SUBBK, OP_ANDK, OP_ORK, OP_SETB,
                      OP_CLRB, OP_CMPK, OP_WADD, OP_WSUB};
  endfunction

  function automatic logic is_branch(input cabx_op_t op);
    return op inside {OP_BFH, OP_BFL, OP_BEQ, OP_BNE, OP_BCS, OP_BSH, OP_BNEG};
  endfunction

  function automatic logic is_skip(input cabx_op_t op);
    return op inside {OP_SKEQ, OP_SKRL, OP_SKRH, OP_SKIL, OP_SKIH};
  endfunction

  // ==========================================
  // state
  typedef enum logic {ST_IDLE, ST_WAIT} cabx_phase_t;

  typedef struct packed {
    cabx_phase_t      phase;
    logic [2:0]       left;
    logic [15:0]      pc;
    logic [7:0]       flags;
    logic [31:0][7:0] regs;
    logic             retire;
    logic [7:0]       peek;
  } cabx_core_state_t;

  cabx_core_state_t state_reg;
  cabx_core_state_t state_next;

  logic          accept;
  logic [7:0]    a_val;
  logic [7:0]    ah_val;
  logic [7:0]    r_val;
  logic [7:0]    b_val;
  logic          a_lt_b;
  logic [15:0]   pc_plus1;
  logic [15:0]   rel_target;
  logic [15:0]   z_ptr;
  logic [15:0]   skip_pc;
  logic [15:0]   stack_top;
  logic          branch_hit;
  logic          skip_hit;
  logic          push;
  logic          pop;
  logic [2:0]    cycles;
  cabx_alu_res_t alu;

  // ==========================================
  // operands and targets
  always_comb
  begin
    accept     = instr_valid && (state_reg.phase == ST_IDLE);
    a_val      = state_reg.regs[instr.rd];
    ah_val     = state_reg.regs[5'(instr.rd + PAIR_STEP)];
    r_val      = state_reg.regs[instr.rr];
    b_val      = is_imm(instr.op) ? instr.imm : r_val;
    a_lt_b     = (a_val < b_val);
    pc_plus1   = state_reg.pc + PC_STEP;
    rel_target = pc_plus1 + {{4{instr.offset[11]}}, instr.offset};
    z_ptr      = {state_reg.regs[ZPTR_HI], state_reg.regs[ZPTR_LO]};
    skip_pc    = state_reg.pc + (instr.two_word ? SKIP_TWO : SKIP_ONE);
    case (instr.op)
      OP_BFH:  branch_hit = state_reg.flags[instr.bsel];
      OP_BFL:  branch_hit = !state_reg.flags[instr.bsel];
      OP_BEQ:  branch_hit = state_reg.flags[FLAG_Z];
      OP_BNE:  branch_hit = !state_reg.flags[FLAG_Z];
      OP_BCS:  branch_hit = state_reg.flags[FLAG_C];
      OP_BSH:  branch_hit = !state_reg.flags[FLAG_C];
      OP_BNEG: branch_hit = state_reg.flags[FLAG_N];
      default: branch_hit = 1'b0;
    endcase
    case (instr.op)
      OP_SKEQ: skip_hit = (a_val == r_val);
      OP_SKRL: skip_hit = !r_val[instr.bsel];
      OP_SKRH: skip_hit = r_val[instr.bsel];
      OP_SKIL: skip_hit = !io_rdata[instr.bsel];
      OP_SKIH: skip_hit = io_rdata[instr.bsel];
      default: skip_hit = 1'b0;
    endcase
  end

  cabx_alu u_alu (
    .op    (instr.op),
    .a     (a_val),
    .ah    (ah_val),
    .b     (b_val),
    .flags (state_reg.flags),
    .res   (alu)
  );

  cabx_ret_stack #(
    .DEPTH (STACK_DEPTH),
    .W     (16)
  ) u_stack (
    .clk       (clk),
    .rst       (rst),
    .push      (push),
    .pop       (pop),
    .push_data (pc_plus1),
    .top       (stack_top)
  );

  // ==========================================
  // next state
  always_comb
  begin
    state_next        = state_reg;
    state_next.retire = 1'b0;
    push              = 1'b0;
    pop               = 1'b0;
    cycles            = CYC_ONE;
    if (accept)
    begin
      state_next.pc    = pc_plus1;
      state_next.flags = alu.flags;
      if (alu.wr)
        state_next.regs[instr.rd] = alu.lo;
      if (alu.wr_pair)
      begin
        state_next.regs[5'(instr.rd + PAIR_STEP)] = alu.hi;
        cycles                                    = CYC_WORD;
      end
      case (instr.op)
        OP_JREL:
        begin
          state_next.pc = rel_target;
          cycles        = CYC_JUMP;
        end
        OP_JIND:
        begin
          state_next.pc = z_ptr;
          cycles        = CYC_JUMP;
        end
        OP_CREL:
        begin
          push          = 1'b1;
          state_next.pc = rel_target;
          cycles        = CYC_CALL;
        end
        OP_CIND:
        begin
          push          = 1'b1;
          state_next.pc = z_ptr;
          cycles        = CYC_CALL;
        end
        OP_RETS, OP_RETINT:
        begin
          pop           = 1'b1;
          state_next.pc = stack_top;
          cycles        = CYC_RET;
          if (instr.op == OP_RETINT)
            state_next.flags[FLAG_I] = 1'b1;
        end
        default: ;
      endcase
      if (branch_hit)
      begin
        state_next.pc = rel_target;
        cycles        = CYC_TAKEN;
      end
      if (skip_hit)
      begin
        state_next.pc = skip_pc;
        cycles        = instr.two_word ? CYC_SKIP2 : CYC_SKIP1;
      end
      if (cycles == CYC_ONE)
        state_next.retire = 1'b1;
      else
      begin
        state_next.phase = ST_WAIT;
        state_next.left  = cycles - CYC_ONE;
      end
    end
    else
    begin
      case (state_reg.phase)
        ST_WAIT:
        begin
          state_next.left = state_reg.left - CYC_ONE;
          if (state_reg.left == CYC_ONE)
          begin
            state_next.phase  = ST_IDLE;
            state_next.retire = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // a load in the same cycle overrides the instruction's write
    if (load_valid)
      state_next.regs[load_addr] = load_data;
    state_next.peek = state_reg.regs[peek_addr];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg       <= '0;
      state_reg.phase <= ST_IDLE;
      state_reg.pc    <= PC_RESET;
      state_reg.flags <= FLAGS_RESET;
    end
    else
      state_reg <= state_next;
  end

  assign instr_ready  = (state_reg.phase == ST_IDLE);
  assign retire       = state_reg.retire;
  assign peek_data    = state_reg.peek;
  assign pc           = state_reg.pc;
  assign status_flags = state_reg.flags;

  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_add_one;
    accept && (instr.op inside {OP_ADD, OP_ADDC}) |=> instr_ready && retire;
  endproperty
  a_add_one: assert property (p_add_one)
    else $error("add did not finish in one cycle");

  property p_wadd_two;
    accept && (instr.op == OP_WADD) |=> !instr_ready ##1 (instr_ready && retire);
  endproperty
  a_wadd_two: assert property (p_wadd_two)
    else $error("word add did not take two cycles");

  property p_wsub_sign;
    accept && (instr.op == OP_WSUB)
      |=> (status_flags[FLAG_S] == (status_flags[FLAG_N] ^ status_flags[FLAG_V])) ##1 instr_ready;
  endproperty
  a_wsub_sign: assert property (p_wsub_sign)
    else $error("word subtract sign or timing wrong");

  property p_sub_borrow;
    accept && (instr.op == OP_SUB) |=> status_flags[FLAG_C] == $past(a_lt_b);
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("subtract carry does not match operands");

  property p_and_keep_c;
    accept && (instr.op inside {OP_AND, OP_ANDK})
      |=> $stable(status_flags[FLAG_C]) && !status_flags[FLAG_V];
  endproperty
  a_and_keep_c: assert property (p_and_keep_c)
    else $error("logic AND disturbed carry or overflow");

  property p_indirect_jump;
    accept && (instr.op == OP_JIND) |=> (pc == $past(z_ptr)) && $stable(status_flags) ##1 instr_ready;
  endproperty
  a_indirect_jump: assert property (p_indirect_jump)
    else $error("indirect jump target or timing wrong");

  property p_indirect_call;
    accept && (instr.op == OP_CIND) |=> !instr_ready [*2] ##1 instr_ready;
  endproperty
  a_indirect_call: assert property (p_indirect_call)
    else $error("indirect call did not take three cycles");

  property p_rel_jump;
    accept && (instr.op == OP_JREL) |=> pc == $past(rel_target);
  endproperty
  a_rel_jump: assert property (p_rel_jump)
    else $error("relative jump target wrong");

  property p_skip;
    accept && is_skip(instr.op) && skip_hit |=> pc == $past(skip_pc);
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip did not advance by two or three");

  property p_cmp_nowrite;
    accept && !load_valid && (instr.op inside {OP_CMP, OP_CMPC, OP_CMPK}) |=> $stable(state_reg.regs);
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite)
    else $error("compare wrote a register");

  property p_branch_not;
    accept && is_branch(instr.op) && !branch_hit |=> instr_ready && (pc == $past(pc_plus1));
  endproperty
  a_branch_not: assert property (p_branch_not)
    else $error("untaken branch not one cycle");

  property p_ret_four;
    accept && (instr.op inside {OP_RETS, OP_RETINT}) |=> !instr_ready [*3] ##1 (instr_ready && retire);
  endproperty
  a_ret_four: assert property (p_ret_four)
    else $error("return did not take four cycles");

  c_word:   cover property (accept && (instr.op == OP_WADD));
  c_taken:  cover property (accept && is_branch(instr.op) && branch_hit);
  c_skip2:  cover property (accept && skip_hit && instr.two_word);
  c_reti:   cover property (accept && (instr.op == OP_RETINT));

endmodule

// ---- hw/cabx_pkg.sv ----
// cabx_pkg: opcodes, flag positions, cycle counts and carriers
// assumes a decoder outside fills cabx_instr_t on the core clock
package cabx_pkg;

  // ==========================================
  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ==========================================
  // reset values and fixed operands
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_ONES   = 8'hff;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [7:0]  NEG_MIN     = 8'h80;
  localparam logic [7:0]  POS_MAX     = 8'h7f;
  localparam logic [4:0]  ZPTR_LO     = 5'h1e;
  localparam logic [4:0]  ZPTR_HI     = 5'h1f;
  localparam logic [4:0]  PAIR_STEP   = 5'h01;
  localparam logic [15:0] PC_STEP     = 16'h0001;
  localparam logic [15:0] SKIP_ONE    = 16'h0002;
  localparam logic [15:0] SKIP_TWO    = 16'h0003;

  // ==========================================
  // cycle counts
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_WORD  = 3'h2;
  localparam logic [2:0] CYC_JUMP  = 3'h2;
  localparam logic [2:0] CYC_CALL  = 3'h3;
  localparam logic [2:0] CYC_RET   = 3'h4;
  localparam logic [2:0] CYC_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP1 = 3'h2;
  localparam logic [2:0] CYC_SKIP2 = 3'h3;

  // ==========================================
  // operations
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_WADD, OP_SUB, OP_SUBK, OP_SUBB, OP_SUBBK,
    OP_WSUB, OP_AND, OP_ANDK, OP_OR, OP_ORK, OP_XOR, OP_COM, OP_NEG,
    OP_SETB, OP_CLRB, OP_INC, OP_DEC, OP_TEST, OP_ZERO, OP_SETR,
    OP_CMP, OP_CMPC, OP_CMPK, OP_JREL, OP_JIND, OP_CREL, OP_CIND,
    OP_RETS, OP_RETINT, OP_SKEQ, OP_SKRL, OP_SKRH, OP_SKIL, OP_SKIH,
    OP_BFH, OP_BFL, OP_BEQ, OP_BNE, OP_BCS, OP_BSH, OP_BNEG
  } cabx_op_t;

  typedef struct packed {
    cabx_op_t    op;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [7:0]  imm;
    logic [11:0] offset;
    logic [2:0]  bsel;
    logic        two_word;
  } cabx_instr_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] flags;
    logic       wr;
    logic       wr_pair;
  } cabx_alu_res_t;

endpackage

// ---- hw/cabx_ret_stack.sv ----
// cabx_ret_stack: return address stack for calls and returns
// assumes push and pop never in the same cycle; DEPTH a power of two
`timescale 1ns/10ps

module cabx_ret_stack #(
  parameter int DEPTH = 16,
  parameter int W     = 16
)
(
  // clock and reset
  input  logic         clk,
  input  logic         rst,
  // stack operations
  input  logic         push,
  input  logic         pop,
  input  logic [W-1:0] push_data,
  output logic [W-1:0] top
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0]           sp;
    logic [DEPTH-1:0][W-1:0] mem;
  } cabx_stack_state_t;

  cabx_stack_state_t state_reg;
  cabx_stack_state_t state_next;

  // overflow wraps and overwrites the oldest entry
  always_comb
  begin
    state_next = state_reg;
    if (push)
    begin
      state_next.mem[state_reg.sp] = push_data;
      state_next.sp                = state_reg.sp + 1'b1;
    end
    else if (pop)
      state_next.sp = state_reg.sp - 1'b1;
  end

  assign top = state_reg.mem[AW'(state_reg.sp - 1'b1)];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule

// ---- sim/cabx_core_tb.sv ----
// cabx_core_tb: self-checking bench for the execution core
// assumes cabx_pkg and cabx_core compiled first; drives ports at falling edge
`timescale 1ns/10ps

module cabx_core_tb
  import cabx_pkg::*;
;
  // ==========================================
  // clock, reset and ports
  logic        clk;
  logic        rst;
  logic        instr_valid;
  cabx_instr_t instr;
  logic        instr_ready;
  logic        retire;
  logic [7:0]  io_rdata;
  logic        load_valid;
  logic [4:0]  load_addr;
  logic [7:0]  load_data;
  logic [4:0]  peek_addr;
  logic [7:0]  peek_data;
  logic [15:0] pc;
  logic [7:0]  status_flags;
  int          n_fail;
  int          n_tests;

  always #2.5 clk = ~clk;

  cabx_core #(.STACK_DEPTH(4)) DUT (
    .clk         (clk),
    .rst         (rst),
    .instr_valid (instr_valid),
    .instr       (instr),
    .instr_ready (instr_ready),
    .retire      (retire),
    .io_rdata    (io_rdata),
    .load_valid  (load_valid),
    .load_addr   (load_addr),
    .load_data   (load_data),
    .peek_addr   (peek_addr),
    .peek_data   (peek_data),
    .pc          (pc),
    .status_flags(status_flags)
  );

  // ==========================================
  // check and verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // access tasks
  // load valid stays high across a run of loads, dropped by ld_end
  task automatic ld(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    load_valid = 1'b1;
    load_addr  = a;
    load_data  = d;
  endtask

  task automatic ld_end();
    @(negedge clk);
    load_valid = 1'b0;
  endtask

  task automatic peek(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clk);
    peek_addr = a;
    @(negedge clk);
    chk({8'h00, peek_data}, {8'h00, exp});
  endtask

  // offer one instruction, count cycles to retire, then check pc and flags
  task automatic run(input cabx_op_t op, input logic [4:0] rd, input logic [4:0] rr, input logic [7:0] imm,
                     input logic [11:0] off, input logic [2:0] bs, input logic tw, input logic [2:0] cyc,
                     input logic [15:0] epc, input logic [7:0] efl);
    logic [2:0] cnt;
    @(negedge clk);
    chk({15'h0000, instr_ready}, 16'h0001);
    instr       = {op, rd, rr, imm, off, bs, tw};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    cnt = 3'h1;
    while (retire !== 1'b1 && cnt < 3'h6)
    begin
      @(negedge clk);
      cnt++;
    end
    // a hang counts once and ends the run at the verdict
    if (retire !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
    else
    begin
      chk({13'h0000, cnt}, {13'h0000, cyc});
      chk(pc, epc);
      chk({8'h00, status_flags}, {8'h00, efl});
    end
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    io_rdata = 8'h08;
    load_valid = 1'b0;
    load_addr = 5'h00;
    load_data = 8'h00;
    peek_addr = 5'h00;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(pc, PC_RESET);
    chk({8'h00, status_flags}, {8'h00, FLAGS_RESET});
    ld(5'h01, 8'h0f);
    ld(5'h02, 8'h01);
    ld(5'h03, 8'h00);
    ld(5'h04, 8'ha5);
    ld(ZPTR_LO, 8'h34);
    ld(ZPTR_HI, 8'h12);
    ld_end();
    run(OP_ADD,    5'h01, 5'h02, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0001, 8'h20);
    run(OP_SUB,    5'h03, 5'h02, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0002, 8'h25);
    run(OP_ADDC,   5'h01, 5'h02, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0003, 8'h00);
    peek(5'h01, 8'h12);
    peek(5'h03, 8'hff);
    run(OP_WSUB,   5'h1a, 5'h00, 8'h01, 12'h000, 3'h0, 1'b0, 3'h2, 16'h0004, 8'h15);
    peek(5'h1b, 8'hff);
    run(OP_WADD,   5'h1a, 5'h00, 8'h01, 12'h000, 3'h0, 1'b0, 3'h2, 16'h0005, 8'h03);
    peek(5'h1b, 8'h00);
    run(OP_ANDK,   5'h04, 5'h00, 8'h0f, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0006, 8'h01);
    run(OP_SUBBK,  5'h04, 5'h00, 8'h05, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0007, 8'h25);
    run(OP_CMPK,   5'h04, 5'h00, 8'hff, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0008, 8'h02);
    peek(5'h04, 8'hff);
    run(OP_BEQ,    5'h00, 5'h00, 8'h00, 12'h005, 3'h0, 1'b0, 3'h2, 16'h000e, 8'h02);
    run(OP_BNE,    5'h00, 5'h00, 8'h00, 12'h005, 3'h0, 1'b0, 3'h1, 16'h000f, 8'h02);
    run(OP_XOR,    5'h04, 5'h04, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0010, 8'h02);
    run(OP_SETB,   5'h04, 5'h00, 8'h80, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0011, 8'h04);
    run(OP_CLRB,   5'h04, 5'h00, 8'h80, 12'h000, 3'h0, 1'b0, 3'h1, 16'h0012, 8'h02);
    run(OP_BNEG,   5'h00, 5'h00, 8'h00, 12'hffd, 3'h0, 1'b0, 3'h1, 16'h0013, 8'h02);
    run(OP_BFH,    5'h00, 5'h00, 8'h00, 12'h010, 3'h1, 1'b0, 3'h2, 16'h0024, 8'h02);
    run(OP_BSH,    5'h00, 5'h00, 8'h00, 12'h002, 3'h0, 1'b0, 3'h2, 16'h0027, 8'h02);
    run(OP_BCS,    5'h00, 5'h00, 8'h00, 12'h002, 3'h0, 1'b0, 3'h1, 16'h0028, 8'h02);
    run(OP_SKEQ,   5'h01, 5'h01, 8'h00, 12'h000, 3'h0, 1'b1, 3'h3, 16'h002b, 8'h02);
    run(OP_SKIH,   5'h00, 5'h00, 8'h00, 12'h000, 3'h3, 1'b0, 3'h2, 16'h002d, 8'h02);
    run(OP_SKRL,   5'h00, 5'h02, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h002e, 8'h02);
    run(OP_JREL,   5'h00, 5'h00, 8'h00, 12'hffe, 3'h0, 1'b0, 3'h2, 16'h002d, 8'h02);
    run(OP_CREL,   5'h00, 5'h00, 8'h00, 12'h00a, 3'h0, 1'b0, 3'h3, 16'h0038, 8'h02);
    run(OP_CIND,   5'h00, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h3, 16'h1234, 8'h02);
    run(OP_RETS,   5'h00, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h4, 16'h0039, 8'h02);
    run(OP_RETINT, 5'h00, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h4, 16'h002e, 8'h82);
    run(OP_JIND,   5'h00, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h2, 16'h1234, 8'h82);
    run(OP_ORK,    5'h04, 5'h00, 8'h81, 12'h000, 3'h0, 1'b0, 3'h1, 16'h1235, 8'h84);
    run(OP_TEST,   5'h04, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h1236, 8'h84);
    peek(5'h04, 8'h81);
    run(OP_BNEG,   5'h00, 5'h00, 8'h00, 12'h002, 3'h0, 1'b0, 3'h2, 16'h1239, 8'h84);
    run(OP_COM,    5'h04, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h123a, 8'h81);
    run(OP_NEG,    5'h04, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h123b, 8'ha5);
    run(OP_INC,    5'h03, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h123c, 8'ha3);
    run(OP_SETR,   5'h03, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h123d, 8'ha3);
    peek(5'h03, 8'hff);
    run(OP_ZERO,   5'h04, 5'h00, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h123e, 8'ha3);
    peek(5'h04, 8'h00);
    run(OP_SKIL,   5'h00, 5'h00, 8'h00, 12'h000, 3'h3, 1'b0, 3'h1, 16'h123f, 8'ha3);
    run(OP_BFL,    5'h00, 5'h00, 8'h00, 12'h004, 3'h2, 1'b0, 3'h2, 16'h1244, 8'ha3);
    run(OP_CMPC,   5'h01, 5'h02, 8'h00, 12'h000, 3'h0, 1'b0, 3'h1, 16'h1245, 8'h80);
    run(OP_SKRH,   5'h00, 5'h02, 8'h00, 12'h000, 3'h0, 1'b1, 3'h3, 16'h1248, 8'h80);
    report_and_stop();
  end
endmodule
